// ===== sim/core_seq_model.sv
// Stand-in for the core sequencer: retires, returns and starts calls
`timescale 1ns/1ps
module core_seq_model (
    input wire logic clock, // System clock
    input wire logic rst_b, // Active-low reset
    input wire logic instr_go, // Retire one instruction
    input wire logic ret_go, // Finish one return
    input wire logic [3:0] ack_wait, // Call start delay
    input wire logic call_req, // Call request seen
    output logic instr_done, // Instruction retired
    output logic return_from_irq_instr_done, // Return finished
    output logic call_ack // Call started
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic next_ack;
    logic next_instr;
    logic next_ret;
    // =========================================
    // Next values; no retiring while a call is due, return beats retire
    always_comb begin
        next_cnt = (call_req && !call_ack) ? cnt + 4'h1 : 4'h0;
        next_ack = call_req && !call_ack && cnt >= ack_wait;
        next_instr = instr_go && !ret_go && !call_req;
        next_ret = ret_go;
    end
    // Registers only
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 4'h0;
            call_ack <= 1'b0;
            instr_done <= 1'b0;
            return_from_irq_instr_done <= 1'b0;
        end else begin
            cnt <= next_cnt;
            call_ack <= next_ack;
            instr_done <= next_instr;
            return_from_irq_instr_done <= next_ret;
        end
    end
endmodule // core_seq_model

// ===== sim/two_level_vectored_irq_ctrl_tb.sv
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
module two_level_vectored_irq_ctrl_tb;
    import irq_ctrl_pkg::*;
    localparam int NF = NUM_SRC*FLAGS_PER_SRC;
    typedef struct packed {logic [4:0] src; logic [VEC_W-1:0] vec; logic ac;} row_t;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [NF-1:0] ev = '0, sset = '0, sclr = '0, pending;
    logic ie_wr = 1'b0;
    logic [7:0] ie_wd = 8'h00, ie_rdata;
    logic [NUM_SRC-1:0] en = 17'h1feff, pri = '0;
    logic instr_go = 1'b0, ret_go = 1'b0, instr_done, return_from_irq_instr_done, call_ack, call_req;
    logic [3:0] ack_wait = 4'h0;
    logic [VEC_W-1:0] call_vector;
    logic [1:0] in_service;
    // Source 8 stays disabled, so its flag must stay pending until the mid-run reset
    logic [NF-1:0] stuck = NF'(1) << 32;
    int n_mismatch = 0;
    int checks_done = 0;
    int b;
    row_t rows [8] = '{'{5'd0, 16'h0003, 1'b1}, '{5'd1, 16'h000b, 1'b1},
        '{5'd2, 16'h0013, 1'b1}, '{5'd3, 16'h001b, 1'b1}, '{5'd4, 16'h0023, 1'b0},
        '{5'd7, 16'h003b, 1'b0}, '{5'd15, 16'h007b, 1'b0}, '{5'd16, 16'h0083, 1'b0}};
    two_level_vectored_irq_ctrl two_level_vectored_irq_ctrl_i (.CLOCK(clock), .RST_B(rst_b),
        .SRC_EVENT(ev), .SW_SET(sset), .SW_CLR(sclr), .IE_WR(ie_wr), .IE_WDATA(ie_wd),
        .SRC_ENABLE(en), .SRC_PRIORITY(pri), .INSTR_DONE(instr_done), .RETURN_FROM_IRQ_INSTR_DONE(return_from_irq_instr_done),
        .CALL_ACK(call_ack), .CALL_REQ(call_req), .CALL_VECTOR(call_vector),
        .IE_RDATA(ie_rdata), .PENDING(pending), .IN_SERVICE(in_service));
    core_seq_model core_seq_model_i (.clock(clock), .rst_b(rst_b), .instr_go(instr_go),
        .ret_go(ret_go), .ack_wait(ack_wait), .call_req(call_req), .instr_done(instr_done),
        .return_from_irq_instr_done(return_from_irq_instr_done), .call_ack(call_ack));
    // =========================================
    // Clock and watchdog; the run needs well under 4000 cycles
    initial forever #2.5 clock = ~clock;
    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check_vec(input logic [VEC_W-1:0] got, input logic [VEC_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: vector %h want %h", $time, got, exp);
        end
    endtask
    task automatic check_flags(input logic [NF-1:0] got, input logic [NF-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: bits %h want %h", $time, got, exp);
        end
    endtask
    // =========================================
    // Drivers; checks always run 1 ns after an edge, once outputs settle
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic drive(input int kind, input int bit_no);
        @(posedge clock);
        case (kind)
            0: sset[bit_no] <= 1'b1;
            1: sclr[bit_no] <= 1'b1;
            2: ev[bit_no] <= 1'b1;
            3: instr_go <= 1'b1;
            default: ret_go <= 1'b1;
        endcase
        @(posedge clock);
        {ev, sset, sclr, instr_go, ret_go} <= '0;
        #1;
    endtask
    task automatic wr_ie(input logic [7:0] d);
        @(posedge clock);
        {ie_wr, ie_wd} <= {1'b1, d};
        @(posedge clock);
        ie_wr <= 1'b0;
        tick(1);
    endtask
    task automatic wait_req(input logic [VEC_W-1:0] exp);
        for (int i = 0; i < 30 && call_req !== 1'b1; i++) tick(1);
        check_flags(NF'(call_req), NF'(1));
        check_vec(call_vector, exp);
        tick(1);
        check_vec(call_vector, exp);
        for (int i = 0; i < 30 && call_req !== 1'b0; i++) tick(1);
        tick(1);
    endtask
    task automatic serve(input logic [VEC_W-1:0] exp, input logic [1:0] ins);
        drive(3, 0);
        wait_req(exp);
        check_flags(NF'(in_service), NF'(ins));
    endtask
    // Software clears its flag, returns, then one more instruction retires
    task automatic leave(input int bit_no);
        drive(1, bit_no);
        drive(4, 0);
        drive(3, 0);
    endtask
    // =========================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        tick(4);
        check_flags(NF'(ie_rdata), '0);
        check_vec(call_vector, RESET_VEC);
        drive(0, 32);
        drive(2, 0);
        check_flags(pending, stuck | NF'(1));
        wr_ie(8'h01);
        drive(3, 0);
        tick(4);
        check_flags(NF'(call_req), '0);
        check_flags(pending, stuck | NF'(1));
        wr_ie(8'hff);
        check_flags(NF'(ie_rdata), NF'(8'hff));
        serve(16'h0003, 2'b01);
        leave(0);
        // Table of sources, alternating prompt and slow call start
        for (int i = 0; i < 8; i++) begin
            b = 4*rows[i].src + i % 4;
            ack_wait <= (i % 2) ? 4'd3 : 4'd0;
            drive(0, b);
            check_flags(pending, stuck | (NF'(1) << b));
            serve(rows[i].vec, 2'b01);
            check_flags(pending, stuck | (rows[i].ac ? '0 : NF'(1) << b));
            leave(b);
            check_flags(NF'(in_service), '0);
        end
        // Two levels, nesting and fixed order
        @(posedge clock);
        pri <= 17'h00280;
        drive(0, 20);
        drive(0, 36);
        drive(0, 8);
        drive(0, 28);
        serve(16'h003b, 2'b10);
        drive(3, 0);
        tick(4);
        check_flags(NF'(in_service), NF'(2'b10));
        leave(28);
        tick(1);
        check_flags(NF'(call_req), NF'(1));
        serve(16'h004b, 2'b10);
        leave(36);
        serve(16'h0013, 2'b01);
        drive(0, 36);
        serve(16'h004b, 2'b11);
        leave(36);
        check_flags(NF'(in_service), NF'(2'b01));
        drive(3, 0);
        tick(4);
        check_flags(NF'(call_req), '0);
        drive(4, 0);
        drive(3, 0);
        serve(16'h002b, 2'b01);
        leave(20);
        check_flags(pending, stuck);
        // Event and clear in one cycle: the set must win
        @(posedge clock);
        {ev[0], sclr[0]} <= 2'b11;
        @(posedge clock);
        {ev[0], sclr[0]} <= 2'b00;
        tick(1);
        check_flags(pending, stuck | NF'(1));
        drive(1, 0);
        check_flags(pending, stuck);
        // Reset in mid-run with a flag pending and enables set
        @(posedge clock);
        rst_b <= 1'b0;
        tick(2);
        check_flags(pending, '0);
        check_flags(NF'({ie_rdata, in_service, call_req}), '0);
        @(posedge clock);
        rst_b <= 1'b1;
        tick(4);
        check_flags(NF'(ie_rdata), '0);
        check_vec(call_vector, RESET_VEC);
        final_report();
    end
endmodule // two_level_vectored_irq_ctrl_tb

// ===== src/irq_ctrl_pkg.sv
// Constants and types for the two-level vectored interrupt controller
// How it works
// RULE1: Source events set pending flags regardless of enables
// RULE2: Any flag of a source requests
// RULE3: Request needs flag, source enable, global enable
// RULE4: Disabled flags leave program flow untouched
// RULE5: Call to vector after current instruction ends
// RULE6: Routines end with return from interrupt
// RULE7: Only external and basic timer flags auto-clear
// RULE8: Flag still set after return re-requests
// RULE9: Global enable bit seven masks everything
// RULE10: Flags set while masked stay pending
// RULE11: Software flag set acts like hardware event
// RULE12: High preempts low; nothing preempts high
// RULE13: Preempted low routine resumes after high returns
// RULE14: Higher level wins, then lowest order
// RULE15: Vectors 0x0003 plus eight per order step
// RULE16: Requests sampled and decoded every cycle
// RULE17: Minimum response is seven clocks
// RULE18: One instruction after return before next call
// RULE19: Worst case response is nineteen clocks
// RULE20: Equal or lower waits for return plus instruction
// RULE21: Main enable register resets to zero
// RULE22: Track in-service levels, clear highest on return
// RULE23: Hold vector and call until acknowledged
package irq_ctrl_pkg;
    // ==========================================================
    // Sizes and positions
    localparam int NUM_SRC = 17;
    localparam int FLAGS_PER_SRC = 4;
    localparam int VEC_W = 16;
    localparam int GLOBAL_EN_BIT = 7;
    localparam logic [7:0] IE_RESET = 8'h00;
    localparam logic [7:0] IE_SFR_ADDR = 8'ha8;
    localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
    localparam logic [VEC_W-1:0] VEC_STEP = 16'h0008;
    localparam logic [VEC_W-1:0] RESET_VEC = 16'h0000;
    // Sources whose flags clear in hardware on vector entry
    localparam logic [NUM_SRC-1:0] AUTO_CLR = 17'h0000f;
    // Latency figures in system clocks
    localparam int DETECT_CLKS = 1;
    localparam int CALL_CLKS = 5;
    localparam int MIN_RESP_CLKS = 7;
    localparam int MAX_RESP_CLKS = 19;

    typedef enum logic [1:0] {ST_IDLE, ST_CALL, ST_AFTER_RET} seq_state_t;

    typedef struct packed {
        logic valid;
        logic high;
        logic [4:0] order;
    } winner_t;
endpackage

// ===== src/two_level_vectored_irq_ctrl.sv
// Two-level vectored interrupt controller for the core sequencer
`timescale 1ns/1ps
module two_level_vectored_irq_ctrl
    import irq_ctrl_pkg::*;
(
    input wire logic CLOCK, // System clock, 200 MHz
    input wire logic RST_B, // Async reset, active low
    input wire logic [NUM_SRC*FLAGS_PER_SRC-1:0] SRC_EVENT, // Hardware event pulses
    input wire logic [NUM_SRC*FLAGS_PER_SRC-1:0] SW_SET, // Software flag set pulses
    input wire logic [NUM_SRC*FLAGS_PER_SRC-1:0] SW_CLR, // Software flag clear pulses
    input wire logic IE_WR, // Write strobe for main enable register
    input wire logic [7:0] IE_WDATA, // Main enable write data
    input wire logic [NUM_SRC-1:0] SRC_ENABLE, // Per-source enables (bits 0..6 ignored)
    input wire logic [NUM_SRC-1:0] SRC_PRIORITY, // Per-source high priority
    input wire logic INSTR_DONE, // Core finished an instruction
    input wire logic RETURN_FROM_IRQ_INSTR_DONE, // Core finished a return from interrupt
    input wire logic CALL_ACK, // Core started the long call
    output logic CALL_REQ, // Long call request
    output logic [VEC_W-1:0] CALL_VECTOR, // Vector address of the call
    output logic [7:0] IE_RDATA, // Main enable register contents
    output logic [NUM_SRC*FLAGS_PER_SRC-1:0] PENDING, // Pending flags
    output logic [1:0] IN_SERVICE // Bit1 high level, bit0 low level
);
    // ==========================================================
    // Reset synchroniser
    logic rst_s1, rst_s2;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end
    wire rst_n = rst_s2;

    // ==========================================================
    // State declarations
    logic [NUM_SRC*FLAGS_PER_SRC-1:0] flags, next_flags;
    logic [7:0] ie_reg, next_ie_reg;
    seq_state_t state, next_state;
    logic [1:0] in_svc, next_in_svc;
    logic [VEC_W-1:0] vec, next_vec;
    logic [4:0] call_src, next_call_src;
    logic call_high, next_call_high;
    winner_t win;
    logic [NUM_SRC-1:0] req, src_en, vec_clear;

    // ==========================================================
    // Per-source request terms
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            // Bits 0..6 of the main register carry the first seven enables
            if (g < GLOBAL_EN_BIT) begin : g_main
                assign src_en[g] = ie_reg[g];
            end else begin : g_ext
                assign src_en[g] = SRC_ENABLE[g];
            end
            assign req[g] = (|flags[g*FLAGS_PER_SRC +: FLAGS_PER_SRC]) //RULE2
                            && src_en[g] && ie_reg[GLOBAL_EN_BIT]; //RULE3 RULE9 RULE4
            assign vec_clear[g] = (state == ST_CALL) && CALL_ACK
                                  && (call_src == 5'(g)) && AUTO_CLR[g]; //RULE7
        end
    endgenerate

    // ==========================================================
    // Pending flags: set wins over any clear, so an event that lands
    // with a software or vector clear is never lost
    always_comb begin
        next_flags = flags;
        for (int i = 0; i < NUM_SRC*FLAGS_PER_SRC; i++) begin
            if (SW_CLR[i] || vec_clear[i/FLAGS_PER_SRC])
                next_flags[i] = 1'b0;
            if (SRC_EVENT[i] || SW_SET[i])
                next_flags[i] = 1'b1; //RULE1 RULE11 RULE10
        end
    end

    // Main enable register, plain write
    always_comb begin
        next_ie_reg = IE_WR ? IE_WDATA : ie_reg;
    end

    // ==========================================================
    // Arbiter: evaluated every cycle, high level first, lowest order
    always_comb begin
        win = '0;
        for (int i = NUM_SRC-1; i >= 0; i--) begin
            if (req[i] && !SRC_PRIORITY[i] && !win.high) begin
                win.valid = 1'b1; //RULE16
                win.order = i[4:0]; //RULE14
            end
        end
        for (int i = NUM_SRC-1; i >= 0; i--) begin
            if (req[i] && SRC_PRIORITY[i]) begin
                win.valid = 1'b1;
                win.high = 1'b1; //RULE14
                win.order = i[4:0];
            end
        end
    end

    // A winner may enter only above the level in service. Only two
    // levels exist, so a pair of flags is enough and no stack is kept.
    logic can_take;
    always_comb begin
        if (in_svc[1])
            can_take = 1'b0; //RULE12
        else if (in_svc[0])
            can_take = win.high; //RULE12 RULE20
        else
            can_take = 1'b1;
    end

    // ==========================================================
    // Call sequencer. The detect cycle is the registered flag; the
    // call is issued at the end of the instruction in flight, which
    // gives the seven-clock best case with a one-cycle instruction.
    // After a return at least one instruction retires before a call.
    always_comb begin
        next_state = state;
        next_in_svc = in_svc;
        next_vec = vec;
        next_call_src = call_src;
        next_call_high = call_high;
        case (state)
            ST_IDLE: begin
                if (RETURN_FROM_IRQ_INSTR_DONE) begin
                    // Return pops the highest active level
                    if (in_svc[1])
                        next_in_svc[1] = 1'b0; //RULE22 RULE13
                    else
                        next_in_svc[0] = 1'b0; //RULE22
                    next_state = ST_AFTER_RET; //RULE18 RULE8
                end else if (INSTR_DONE && win.valid && can_take) begin
                    next_state = ST_CALL; //RULE5 RULE17
                    next_call_src = win.order;
                    next_call_high = win.high;
                    next_vec = VEC_BASE + VEC_STEP * {11'h000, win.order}; //RULE15
                end
            end
            ST_AFTER_RET: begin
                // The one instruction after a return has retired; a request
                // that still stands enters at its end, like any other
                if (INSTR_DONE && win.valid && can_take) begin
                    next_state = ST_CALL; //RULE8 RULE18
                    next_call_src = win.order;
                    next_call_high = win.high;
                    next_vec = VEC_BASE + VEC_STEP * {11'h000, win.order}; //RULE15
                end else if (INSTR_DONE) begin
                    next_state = ST_IDLE; //RULE20 RULE19
                end
            end
            ST_CALL: begin
                if (CALL_ACK) begin
                    next_state = ST_IDLE; //RULE23
                    if (call_high)
                        next_in_svc[1] = 1'b1; //RULE22
                    else
                        next_in_svc[0] = 1'b1; //RULE22
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
            ie_reg <= IE_RESET; //RULE21
            state <= ST_IDLE;
            in_svc <= 2'h0;
            vec <= RESET_VEC;
            call_src <= 5'h00;
            call_high <= 1'b0;
        end else begin
            flags <= next_flags;
            ie_reg <= next_ie_reg;
            state <= next_state;
            in_svc <= next_in_svc;
            vec <= next_vec;
            call_src <= next_call_src;
            call_high <= next_call_high;
        end
    end

    // Outputs straight from flops
    always_comb begin
        CALL_REQ = (state == ST_CALL); //RULE23
        CALL_VECTOR = vec;
        IE_RDATA = ie_reg;
        PENDING = flags;
        IN_SERVICE = in_svc;
    end

    // ==========================================================
    // Assertions
    property p_no_req_masked;
        @(posedge CLOCK) disable iff (!rst_n)
        (!ie_reg[GLOBAL_EN_BIT] && state != ST_CALL) |=> !CALL_REQ;
    endproperty
    a_no_req_masked: assert property (p_no_req_masked) else $error("call while masked"); //RULE9

    property p_hold_call;
        @(posedge CLOCK) disable iff (!rst_n)
        (CALL_REQ && !CALL_ACK) |=> (CALL_REQ && $stable(CALL_VECTOR));
    endproperty
    a_hold_call: assert property (p_hold_call) else $error("call dropped early"); //RULE23

    property p_vec_range;
        @(posedge CLOCK) disable iff (!rst_n)
        CALL_REQ |-> (CALL_VECTOR == VEC_BASE + VEC_STEP * {11'h000, call_src});
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("bad vector"); //RULE15

    property p_high_no_preempt;
        @(posedge CLOCK) disable iff (!rst_n)
        (in_svc[1] && state == ST_IDLE && !RETURN_FROM_IRQ_INSTR_DONE) |=> !CALL_REQ;
    endproperty
    a_high_no_preempt: assert property (p_high_no_preempt) else $error("high preempted"); //RULE12

    property p_after_ret;
        @(posedge CLOCK) disable iff (!rst_n)
        ((RETURN_FROM_IRQ_INSTR_DONE && state == ST_IDLE) || (state == ST_AFTER_RET && !INSTR_DONE))
        |=> !CALL_REQ;
    endproperty
    a_after_ret: assert property (p_after_ret) else $error("no gap after return"); //RULE18

    property p_set_wins;
        @(posedge CLOCK) disable iff (!rst_n)
        (SRC_EVENT[0] && SW_CLR[0]) |=> PENDING[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost"); //RULE1

    property p_autoclr;
        @(posedge CLOCK) disable iff (!rst_n)
        (CALL_REQ && CALL_ACK && call_src == 5'h00 && !SRC_EVENT[0] && !SW_SET[0])
        |=> !PENDING[0];
    endproperty
    a_autoclr: assert property (p_autoclr) else $error("auto clear missing"); //RULE7

    property p_keep_other;
        @(posedge CLOCK) disable iff (!rst_n)
        (PENDING[16] && !SW_CLR[16]) |=> PENDING[16];
    endproperty
    a_keep_other: assert property (p_keep_other) else $error("flag cleared by hw"); //RULE7

    property p_svc_set;
        @(posedge CLOCK) disable iff (!rst_n)
        (CALL_REQ && CALL_ACK && call_high) |=> IN_SERVICE[1];
    endproperty
    a_svc_set: assert property (p_svc_set) else $error("level not marked"); //RULE22

    // Call entry and exit
    property p_call_at_end;
        @(posedge CLOCK) disable iff (!rst_n)
        (!CALL_REQ ##1 CALL_REQ) |-> $past(INSTR_DONE);
    endproperty
    a_call_at_end: assert property (p_call_at_end) else $error("call mid instr"); //RULE5

    property p_call_live;
        @(posedge CLOCK) disable iff (!rst_n)
        (!CALL_REQ ##1 CALL_REQ) |-> $past(ie_reg[GLOBAL_EN_BIT] && (|req));
    endproperty
    a_call_live: assert property (p_call_live) else $error("call without request"); //RULE3

    property p_ack_drop;
        @(posedge CLOCK) disable iff (!rst_n)
        (CALL_REQ && CALL_ACK) |=> !CALL_REQ;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("call held past ack"); //RULE23

    property p_re_enter;
        @(posedge CLOCK) disable iff (!rst_n)
        (state == ST_AFTER_RET && INSTR_DONE && ie_reg[GLOBAL_EN_BIT] && (|req)
         && in_svc == 2'h0) |=> CALL_REQ;
    endproperty
    a_re_enter: assert property (p_re_enter) else $error("no re-entry after return"); //RULE8

    // Enable register and level tracking
    property p_ie_write;
        @(posedge CLOCK) disable iff (!rst_n)
        IE_WR |=> (IE_RDATA == $past(IE_WDATA));
    endproperty
    a_ie_write: assert property (p_ie_write) else $error("enable write lost"); //RULE9

    property p_ret_pop;
        @(posedge CLOCK) disable iff (!rst_n)
        (RETURN_FROM_IRQ_INSTR_DONE && state == ST_IDLE && in_svc == 2'h3) |=> (IN_SERVICE == 2'h1);
    endproperty
    a_ret_pop: assert property (p_ret_pop) else $error("low level lost on return"); //RULE13

    // Covers for the main scenarios
    c_call: cover property (@(posedge CLOCK) disable iff (!rst_n) CALL_REQ && CALL_ACK);
    c_nest: cover property (@(posedge CLOCK) disable iff (!rst_n) IN_SERVICE == 2'h3);
    c_ret_re: cover property (@(posedge CLOCK) disable iff (!rst_n)
        state == ST_AFTER_RET ##1 state == ST_IDLE ##[1:20] CALL_REQ);
    c_re_enter: cover property (@(posedge CLOCK) disable iff (!rst_n)
        state == ST_AFTER_RET && INSTR_DONE ##1 CALL_REQ);
endmodule // two_level_vectored_irq_ctrl
